// ===== core/ccr_defines.svh
/*
 * Constants for the processor control register set: register selects, field
 * positions, reset values, page offset width and dual-mode companion offset.
 * Assumes inclusion by bare name from the design module and the checker.
 */
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH

// control register selects on the load/store control port
`define CCR_SEL_FAULT_ADDR 3'h1
`define CCR_SEL_PAGE_DIR 3'h3
`define CCR_SEL_BKPT_ADDR 3'h4
`define CCR_SEL_FLOAT_STAT 3'h2

// page_directory_control fields
`define CCR_PD_TE_BIT 0
`define CCR_PD_DPS_LO 1
`define CCR_PD_DPS_HI 3
`define CCR_PD_BL_BIT 4
`define CCR_PD_INV_BIT 5
`define CCR_PD_LB_BIT 6
`define CCR_PD_CS8_BIT 7
`define CCR_PD_RB_LO 8
`define CCR_PD_RB_HI 9
`define CCR_PD_RC_LO 10
`define CCR_PD_RC_HI 11
`define CCR_PD_DTB_LO 12
`define CCR_PD_DTB_HI 31

// float_status_control fields
`define CCR_FS_FZ_BIT 0
`define CCR_FS_TI_BIT 1
`define CCR_FS_RM_LO 2
`define CCR_FS_RM_HI 3
`define CCR_FS_SI_BIT 7

// reset values
`define CCR_PD_RESET 32'h0000_0080
`define CCR_FS_RESET 32'h0000_0000
`define CCR_BP_RESET 32'h0000_0000
`define CCR_FA_RESET 32'h0000_0000

// fixed page offset width and dual-mode companion distance
`define CCR_PAGE_LOW_BITS 12
`define CCR_COMPANION_OFS 32'h0000_0004

`endif

// ===== core/ccr_pkg.sv
/*
 * Types shared by the control register set: operand sizes, modes and the
 * grouped access and bus-cycle records.
 * Assumes ccr_defines.svh is on the include path.
 */
package ccr_pkg;

    typedef enum logic [2:0] {
        CCR_SZ_8 = 3'h0,
        CCR_SZ_16 = 3'h1,
        CCR_SZ_32 = 3'h2,
        CCR_SZ_64 = 3'h3,
        CCR_SZ_128 = 3'h4
    } ccr_size_t;

    typedef enum logic [1:0] {
        CCR_RM_NEAREST = 2'h0,
        CCR_RM_DOWN = 2'h1,
        CCR_RM_UP = 2'h2,
        CCR_RM_CHOP = 2'h3
    } ccr_round_t;

    // operand access issued by the load/store unit
    typedef struct packed {
        logic valid;
        logic is_write;
        ccr_size_t size;
        logic [31:0] vaddr;
    } ccr_access_t;

    // bus cycle started by the bus unit
    typedef struct packed {
        logic start;
        logic fetch_or_wb;
        logic req_after_lock;
        logic [31:0] paddr;
    } ccr_cycle_t;

    // cache replacement steering
    typedef struct packed {
        logic code_use_block;
        logic data_use_block;
        logic tlb_use_block;
        logic data_repl_off;
        logic [1:0] block;
    } ccr_repl_t;

endpackage : ccr_pkg

// ===== core/ccr_control_regs.sv
/*
 * Processor control register set: breakpoint comparator, page directory and
 * bus options, faulting instruction address and floating-point status.
 * Assumes a single clock, synchronous reset, and that the core pipeline
 * presents control-register loads/stores, operand accesses and events.
 */
//
// Overview of operation
// R1 - trap on operand access matching breakpoint, gated by read/write watch enables
// R2 - ignore one low bit for 16-bit, two for 32-bit accesses
// R3 - breakpoint trap raised before the load or store updates anything
// R4 - translation enable set means virtual addresses go through page tables
// R5 - next-near compares bus addresses ignoring low 12 plus page-bits bits
// R6 - lock asserted on cycles requested after lock set, except fetch/write-back
// R7 - lock drops at next load/store after clear; traps clear lock request
// R8 - invalidate bit triggers cache/TLB invalidate, never stored, reads zero
// R9 - late back-off bit sets two-clock mode unless strapped; only reset clears
// R10 - narrow code fetch set at init; software may clear once, never set
// R11 - replace block field selects block 0..3 and conditions cache flush
// R12 - replacement control: random, all selected, data selected, data disabled
// R13 - directory address is 20-bit base field over twelve zero bits
// R14 - trap loads faulting address with trapping instruction; read-only
// R15 - later reads return reader address, minus 4 in dual-instruction mode
// R16 - underflow traps unless flush-to-zero set, which yields zero result
// R17 - inexact traps only when trap-on-inexact is set
// R18 - sticky inexact set on every inexact result
// R19 - rounding select: nearest-even, down, up, toward zero
// R20 - 64-bit and 128-bit accesses ignore three and four low bits
`timescale 1ns/10ps
`default_nettype none
`include "ccr_defines.svh"

module ccr_control_regs
    import ccr_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic ONE_CLOCK_BACKOFF_STRAP,
    input wire logic CR_WRITE,
    input wire logic CR_READ,
    input wire logic [2:0] CR_SEL,
    input wire logic [31:0] CR_WDATA,
    input wire logic [31:0] CR_INSTR_ADDR,
    input wire logic DUAL_MODE,
    output logic [31:0] CR_RDATA,
    input wire logic READ_WATCH_ENABLE,
    input wire logic WRITE_WATCH_ENABLE,
    input wire ccr_access_t OPERAND_ACCESS,
    output logic BREAKPOINT_TRAP,
    output logic ACCESS_SUPPRESS,
    input wire logic TRAP_TAKEN,
    input wire logic [31:0] TRAP_INSTR_ADDR,
    input wire logic SET_LOCK,
    input wire logic CLEAR_LOCK,
    input wire ccr_cycle_t BUS_CYCLE,
    output logic LOCK_N,
    output logic NEXT_NEAR_N,
    output logic TRANSLATION_ENABLE,
    output logic [31:0] DIRECTORY_ADDR,
    output logic INVALIDATE_CACHES_TLB,
    output logic LATE_BACKOFF_TWO,
    output logic NARROW_CODE_FETCH,
    output ccr_repl_t REPLACEMENT,
    input wire logic FP_UNDERFLOW,
    input wire logic FP_INEXACT,
    output logic FP_RESULT_TRAP,
    output logic FP_FORCE_ZERO,
    output ccr_round_t ROUNDING_SELECT
);

    ////////////////////////////////////////////////////////////////////////
    // register storage
    logic [31:0] breakpoint_address_r;
    logic translation_enable_r;
    logic [2:0] dram_page_bits_r;
    logic bus_lock_request_r;
    logic late_backoff_select_r;
    logic narrow_code_fetch_r;
    logic narrow_cleared_r;
    logic [1:0] replace_block_select_r;
    logic [1:0] replacement_control_r;
    logic [19:0] directory_table_base_r;
    logic [31:0] faulting_instruction_address_r;
    logic fault_fresh_r;
    logic flush_underflow_to_zero_r;
    logic trap_on_inexact_r;
    logic [1:0] rounding_select_r;
    logic sticky_inexact_r;
    logic strap_one_clock_r;
    logic lock_out_r;
    logic [31:0] prev_bus_addr_r;
    logic near_r;
    logic inv_pulse_r;
    logic bp_hit_r;

    logic wr_pd;
    logic wr_fs;
    logic wr_bp;
    logic [31:0] bp_mask;
    logic bp_hit;
    logic [31:0] page_mask;
    logic [5:0] ign_bits;

    // reset images of the two mixed registers, sliced per field below
    localparam logic [31:0] pd_reset_val = `CCR_PD_RESET;
    localparam logic [31:0] fs_reset_val = `CCR_FS_RESET;

    assign wr_pd = CE && CR_WRITE && (CR_SEL == `CCR_SEL_PAGE_DIR);
    assign wr_fs = CE && CR_WRITE && (CR_SEL == `CCR_SEL_FLOAT_STAT);
    assign wr_bp = CE && CR_WRITE && (CR_SEL == `CCR_SEL_BKPT_ADDR);

    ////////////////////////////////////////////////////////////////////////
    // breakpoint comparator: low bits masked by operand size
    always_comb begin
        case (OPERAND_ACCESS.size)
            CCR_SZ_8: bp_mask = 32'hFFFF_FFFF;
            CCR_SZ_16: bp_mask = 32'hFFFF_FFFE; // R2
            CCR_SZ_32: bp_mask = 32'hFFFF_FFFC; // R2
            CCR_SZ_64: bp_mask = 32'hFFFF_FFF8; // R20
            CCR_SZ_128: bp_mask = 32'hFFFF_FFF0; // R20
            default: bp_mask = 32'hFFFF_FFFF;
        endcase
    end

    // watch enables select reads or writes
    assign bp_hit = OPERAND_ACCESS.valid
        && ((OPERAND_ACCESS.vaddr & bp_mask) == (breakpoint_address_r & bp_mask))
        && (OPERAND_ACCESS.is_write ? WRITE_WATCH_ENABLE : READ_WATCH_ENABLE); // R1

    // suppression is combinational so the access never commits
    assign ACCESS_SUPPRESS = bp_hit; // R3

    // trap indication registered for the trap logic
    always_ff @(posedge CLK) begin
        if (RST) begin
            bp_hit_r <= 1'b0;
        end else if (CE) begin
            bp_hit_r <= bp_hit; // R1
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            breakpoint_address_r <= `CCR_BP_RESET;
        end else if (wr_bp) begin
            breakpoint_address_r <= CR_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap latched while reset is held and kept until the next reset, so a
    // page directory store right after release already sees one-clock mode
    always_ff @(posedge CLK) begin
        if (RST) begin
            strap_one_clock_r <= ONE_CLOCK_BACKOFF_STRAP; // R9
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // page directory: plain fields
    always_ff @(posedge CLK) begin
        if (RST) begin
            translation_enable_r <= pd_reset_val[`CCR_PD_TE_BIT];
            dram_page_bits_r <= pd_reset_val[`CCR_PD_DPS_HI:`CCR_PD_DPS_LO];
            replace_block_select_r <= pd_reset_val[`CCR_PD_RB_HI:`CCR_PD_RB_LO];
            replacement_control_r <= pd_reset_val[`CCR_PD_RC_HI:`CCR_PD_RC_LO];
            directory_table_base_r <= pd_reset_val[`CCR_PD_DTB_HI:`CCR_PD_DTB_LO];
        end else if (wr_pd) begin
            translation_enable_r <= CR_WDATA[`CCR_PD_TE_BIT]; // R4
            dram_page_bits_r <= CR_WDATA[`CCR_PD_DPS_HI:`CCR_PD_DPS_LO];
            replace_block_select_r <= CR_WDATA[`CCR_PD_RB_HI:`CCR_PD_RB_LO]; // R11
            replacement_control_r <= CR_WDATA[`CCR_PD_RC_HI:`CCR_PD_RC_LO]; // R12
            directory_table_base_r <= CR_WDATA[`CCR_PD_DTB_HI:`CCR_PD_DTB_LO]; // R13
        end
    end

    // late back-off: set only, ignored when strapped to one-clock mode
    always_ff @(posedge CLK) begin
        if (RST) begin
            late_backoff_select_r <= pd_reset_val[`CCR_PD_LB_BIT];
        end else if (wr_pd && CR_WDATA[`CCR_PD_LB_BIT] && !strap_one_clock_r) begin
            late_backoff_select_r <= 1'b1; // R9
        end
    end

    // narrow fetch: set by init, one software clear allowed
    always_ff @(posedge CLK) begin
        if (RST) begin
            narrow_code_fetch_r <= pd_reset_val[`CCR_PD_CS8_BIT]; // R10
            narrow_cleared_r <= 1'b0;
        end else if (wr_pd && !CR_WDATA[`CCR_PD_CS8_BIT] && !narrow_cleared_r) begin
            narrow_code_fetch_r <= 1'b0; // R10
            narrow_cleared_r <= 1'b1;
        end
    end

    // invalidate is a one-cycle pulse, never stored
    always_ff @(posedge CLK) begin
        if (RST) begin
            inv_pulse_r <= 1'b0;
        end else if (CE) begin
            inv_pulse_r <= wr_pd && CR_WDATA[`CCR_PD_INV_BIT]; // R8
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus lock request: trap clears at once and wins over a set
    always_ff @(posedge CLK) begin
        if (RST) begin
            bus_lock_request_r <= 1'b0;
        end else if (CE) begin
            if (TRAP_TAKEN || bp_hit) begin
                bus_lock_request_r <= 1'b0; // R7
            end else if (SET_LOCK) begin
                bus_lock_request_r <= 1'b1; // R6
            end else if (CLEAR_LOCK) begin
                bus_lock_request_r <= 1'b0; // R7
            end
        end
    end

    // lock output follows qualifying bus cycles, releases at next access once the lock request is clear
    always_ff @(posedge CLK) begin
        if (RST) begin
            lock_out_r <= 1'b0;
        end else if (CE) begin
            if (bus_lock_request_r && BUS_CYCLE.start && !BUS_CYCLE.fetch_or_wb
                && BUS_CYCLE.req_after_lock) begin
                lock_out_r <= 1'b1; // R6
            end else if (!bus_lock_request_r && OPERAND_ACCESS.valid) begin
                lock_out_r <= 1'b0; // R7
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next-near: compare with previous cycle above the DRAM page
    assign ign_bits = 6'(`CCR_PAGE_LOW_BITS) + {3'h0, dram_page_bits_r};
    assign page_mask = 32'hFFFF_FFFF << ign_bits;

    always_ff @(posedge CLK) begin
        if (RST) begin
            prev_bus_addr_r <= 32'h0000_0000;
            near_r <= 1'b0;
        end else if (CE && BUS_CYCLE.start) begin
            prev_bus_addr_r <= BUS_CYCLE.paddr;
            near_r <= ((BUS_CYCLE.paddr & page_mask) == (prev_bus_addr_r & page_mask)); // R5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // faulting instruction address and its first-read marker
    always_ff @(posedge CLK) begin
        if (RST) begin
            faulting_instruction_address_r <= `CCR_FA_RESET;
            fault_fresh_r <= 1'b0;
        end else if (CE) begin
            if (TRAP_TAKEN) begin
                faulting_instruction_address_r <= TRAP_INSTR_ADDR; // R14
                fault_fresh_r <= 1'b1;
            end else if (CR_READ && CR_SEL == `CCR_SEL_FAULT_ADDR) begin
                fault_fresh_r <= 1'b0; // R15
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // float status: control fields and sticky inexact
    always_ff @(posedge CLK) begin
        if (RST) begin
            flush_underflow_to_zero_r <= fs_reset_val[`CCR_FS_FZ_BIT];
            trap_on_inexact_r <= fs_reset_val[`CCR_FS_TI_BIT];
            rounding_select_r <= fs_reset_val[`CCR_FS_RM_HI:`CCR_FS_RM_LO];
        end else if (wr_fs) begin
            flush_underflow_to_zero_r <= CR_WDATA[`CCR_FS_FZ_BIT];
            trap_on_inexact_r <= CR_WDATA[`CCR_FS_TI_BIT];
            rounding_select_r <= CR_WDATA[`CCR_FS_RM_HI:`CCR_FS_RM_LO]; // R19
        end
    end

    // inexact sets win over a software clear in the same cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            sticky_inexact_r <= fs_reset_val[`CCR_FS_SI_BIT];
        end else if (CE) begin
            if (FP_INEXACT) begin
                sticky_inexact_r <= 1'b1; // R18
            end else if (wr_fs) begin
                sticky_inexact_r <= CR_WDATA[`CCR_FS_SI_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux, registered
    always_ff @(posedge CLK) begin
        if (RST) begin
            CR_RDATA <= 32'h0000_0000;
        end else if (CE && CR_READ) begin
            case (CR_SEL)
                `CCR_SEL_BKPT_ADDR: CR_RDATA <= breakpoint_address_r;
                `CCR_SEL_PAGE_DIR: CR_RDATA <= {directory_table_base_r,
                    replacement_control_r, replace_block_select_r, narrow_code_fetch_r,
                    late_backoff_select_r, 1'b0, bus_lock_request_r, dram_page_bits_r,
                    translation_enable_r}; // R8
                `CCR_SEL_FAULT_ADDR: CR_RDATA <= fault_fresh_r ?
                    faulting_instruction_address_r :
                    (DUAL_MODE ? CR_INSTR_ADDR - `CCR_COMPANION_OFS : CR_INSTR_ADDR); // R15
                `CCR_SEL_FLOAT_STAT: CR_RDATA <= {24'h00_0000, sticky_inexact_r, 3'h0,
                    rounding_select_r, trap_on_inexact_r, flush_underflow_to_zero_r};
                default: CR_RDATA <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign BREAKPOINT_TRAP = bp_hit_r; // R1
    assign LOCK_N = ~lock_out_r;
    assign NEXT_NEAR_N = ~near_r;
    assign TRANSLATION_ENABLE = translation_enable_r; // R4
    assign DIRECTORY_ADDR = {directory_table_base_r, 12'h000}; // R13
    assign INVALIDATE_CACHES_TLB = inv_pulse_r;
    assign LATE_BACKOFF_TWO = late_backoff_select_r && !strap_one_clock_r; // R9
    assign NARROW_CODE_FETCH = narrow_code_fetch_r;

    // replacement steering in one driver; order code, data, tlb, off, block
    assign REPLACEMENT = {
        (replacement_control_r == 2'h1), // R12
        (replacement_control_r == 2'h1) || (replacement_control_r == 2'h2), // R12
        (replacement_control_r == 2'h1), // R12
        (replacement_control_r == 2'h3), // R12
        replace_block_select_r // R11
    };

    // floating-point result handling
    assign FP_RESULT_TRAP = (FP_UNDERFLOW && !flush_underflow_to_zero_r)
        || (FP_INEXACT && trap_on_inexact_r); // R16 R17
    assign FP_FORCE_ZERO = FP_UNDERFLOW && flush_underflow_to_zero_r; // R16
    assign ROUNDING_SELECT = ccr_round_t'(rounding_select_r); // R19

endmodule : ccr_control_regs
`default_nettype wire

// ===== sim/ccr_checker.sv
/* port checks for the control register set
   assumes binding to ccr_control_regs with CE held high */
`timescale 1ns/10ps
`default_nettype none
`include "ccr_defines.svh"
module ccr_checker
    import ccr_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CR_WRITE,
    input wire logic [2:0] CR_SEL,
    input wire logic [31:0] CR_WDATA,
    input wire logic READ_WATCH_ENABLE,
    input wire logic WRITE_WATCH_ENABLE,
    input wire ccr_access_t OPERAND_ACCESS,
    input wire logic ACCESS_SUPPRESS,
    input wire logic BREAKPOINT_TRAP,
    input wire ccr_cycle_t BUS_CYCLE,
    input wire logic LOCK_N,
    input wire logic NEXT_NEAR_N,
    input wire logic TRANSLATION_ENABLE,
    input wire logic [31:0] DIRECTORY_ADDR,
    input wire logic INVALIDATE_CACHES_TLB,
    input wire logic LATE_BACKOFF_TWO,
    input wire logic FP_UNDERFLOW,
    input wire logic FP_INEXACT,
    input wire logic FP_RESULT_TRAP,
    input wire logic FP_FORCE_ZERO
);
    // single domain, reset quiets every check
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    ////////////////////////////////////////
    // page directory stores and the invalidate request among them
    sequence pd_write;
        CR_WRITE && CR_SEL == `CCR_SEL_PAGE_DIR;
    endsequence
    sequence inv_write;
        pd_write ##0 CR_WDATA[`CCR_PD_INV_BIT];
    endsequence
    watch_gate_a: assert property (
        ACCESS_SUPPRESS |-> OPERAND_ACCESS.valid && (OPERAND_ACCESS.is_write ?
        WRITE_WATCH_ENABLE : READ_WATCH_ENABLE)) else $error("suppress without enabled access");
    trap_timing_a: assert property (
        BREAKPOINT_TRAP == $past(ACCESS_SUPPRESS)) else $error("trap not one cycle after hit");
    dir_xlate_a: assert property (
        pd_write |=> DIRECTORY_ADDR == {$past(CR_WDATA[31:12]), 12'h000}
        && TRANSLATION_ENABLE == $past(CR_WDATA[0])) else $error("directory outputs stale");
    inv_pulse_a: assert property (
        inv_write |=> INVALIDATE_CACHES_TLB) else $error("invalidate pulse missing");
    late_sticky_a: assert property (
        LATE_BACKOFF_TWO |=> LATE_BACKOFF_TWO) else $error("late back-off cleared");
    lock_cause_a: assert property (
        $fell(LOCK_N) |-> $past(BUS_CYCLE.start && !BUS_CYCLE.fetch_or_wb
        && BUS_CYCLE.req_after_lock)) else $error("lock without eligible cycle");
    lock_release_a: assert property (
        $rose(LOCK_N) |-> $past(OPERAND_ACCESS.valid)) else $error("lock dropped off access");
    near_cause_a: assert property (
        $fell(NEXT_NEAR_N) |-> $past(BUS_CYCLE.start)) else $error("near without cycle");
    uf_flush_a: assert property (
        FP_UNDERFLOW && !FP_INEXACT |-> FP_FORCE_ZERO != FP_RESULT_TRAP)
        else $error("underflow handling wrong");
    nx_quiet_a: assert property (
        !FP_INEXACT && !FP_UNDERFLOW |-> !FP_RESULT_TRAP) else $error("spurious result trap");
endmodule : ccr_checker
`default_nettype wire

// ===== sim/ccr_bus_model.sv
/* bus-side model that starts bus cycles toward the register set
   assumes the bench calls cycle() from its own sequence */
`timescale 1ns/10ps
`default_nettype none
module ccr_bus_model
    import ccr_pkg::*;
(
    input wire logic clk,
    output var ccr_cycle_t bus_cycle
);
    // idle until asked
    initial bus_cycle = '0;
    ////////////////////////////////////////
    // one cycle start, then address lines stop holding the old value
    task automatic cycle(input logic [31:0] addr, input logic fetch);
        @(negedge clk);
        bus_cycle = {1'b1, fetch, 1'b1, addr};
        @(negedge clk);
        bus_cycle.start = 1'b0;
        bus_cycle.paddr = ~addr;
    endtask : cycle
endmodule : ccr_bus_model
`default_nettype wire

// ===== sim/tb_top.sv
/* self-checking bench for the control register set
   assumes ccr_pkg, the design, checker and bus model are compiled first */
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import ccr_pkg::*;
;
    logic clk = 0, rst = 1, wr_s = 0, rd_s = 0, dual = 0, rwe = 1, wwe = 1;
    logic trap = 0, set_l = 0, clr_l = 0, unf = 0, inx = 0, ce = 1, strap = 0;
    logic [2:0] sel = 0;
    logic [31:0] wdata = 0, iaddr = 0, taddr = 0, rdata, dir_addr, r;
    ccr_access_t acc = '0;
    ccr_cycle_t cyc;
    ccr_repl_t repl;
    ccr_round_t rsel;
    logic bk_trap, supp, lock_n, near_n, te, inv, lb2, ncf, fp_trap, fp_zero;
    int num_errors = 0, tests_run = 0, cycles = 0, pd_m, a, i, v;
    // 100 MHz clock
    initial forever #5 clk = ~clk;
    ccr_control_regs dut_u (
        .CLK(clk), .RST(rst), .CE(ce), .ONE_CLOCK_BACKOFF_STRAP(strap),
        .CR_WRITE(wr_s), .CR_READ(rd_s), .CR_SEL(sel), .CR_WDATA(wdata),
        .CR_INSTR_ADDR(iaddr), .DUAL_MODE(dual), .CR_RDATA(rdata),
        .READ_WATCH_ENABLE(rwe), .WRITE_WATCH_ENABLE(wwe), .OPERAND_ACCESS(acc),
        .BREAKPOINT_TRAP(bk_trap), .ACCESS_SUPPRESS(supp), .TRAP_TAKEN(trap),
        .TRAP_INSTR_ADDR(taddr), .SET_LOCK(set_l), .CLEAR_LOCK(clr_l), .BUS_CYCLE(cyc),
        .LOCK_N(lock_n), .NEXT_NEAR_N(near_n), .TRANSLATION_ENABLE(te),
        .DIRECTORY_ADDR(dir_addr), .INVALIDATE_CACHES_TLB(inv), .LATE_BACKOFF_TWO(lb2),
        .NARROW_CODE_FETCH(ncf), .REPLACEMENT(repl), .FP_UNDERFLOW(unf), .FP_INEXACT(inx),
        .FP_RESULT_TRAP(fp_trap), .FP_FORCE_ZERO(fp_zero), .ROUNDING_SELECT(rsel)
    );
    ccr_bus_model bus_u (.clk(clk), .bus_cycle(cyc));
    ////////////////////////////////////////
    // compare and count
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // register store, data released afterwards
    task automatic wr(input logic [2:0] s, input logic [31:0] x);
        @(negedge clk);
        wr_s = 1;
        sel = s;
        wdata = x;
        @(negedge clk);
        wr_s = 0;
        wdata = ~x;
    endtask : wr
    // register load, data valid the cycle after the strobe
    task automatic rd(input logic [2:0] s, output logic [31:0] x);
        @(negedge clk);
        rd_s = 1;
        sel = s;
        @(negedge clk);
        rd_s = 0;
        x = rdata;
    endtask : rd
    // operand access with expected match
    task automatic access(input logic w, input ccr_size_t sz, input logic [31:0] va,
        input logic e);
        @(negedge clk);
        acc = {1'b1, w, sz, va};
        #1 chk("suppress", supp, e);
        @(negedge clk);
        chk("bkpt trap", bk_trap, e);
        acc.valid = 0;
    endtask : access
    task automatic pulse(ref logic p);
        @(negedge clk);
        p = 1;
        @(negedge clk);
        p = 0;
    endtask : pulse
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(94));
        repeat (20) @(negedge clk);
        rst = 0;
        for (i = 0; i < 5; i++) begin
            rd(i[2:0], r);
            chk("reset read", r, i == 3 ? 32'h0000_0080 : 32'h0000_0000);
        end
        pd_m = 32'h0000_0080;
        for (i = 0; i < 4; i++) begin
            v = ($urandom() & (i == 2 ? 32'hFFFF_F35F : 32'hFFFF_F3DF)) | (i << 10);
            v = v | ((i & 1) << 5) | ((i & 2) << 5);
            pd_m = (v & 32'hFFFF_FF4F) | (pd_m & 32'h0000_0040) | (pd_m & v & 32'h0000_0080);
            wr(3'h3, v);
            chk("invalidate", inv, (v >> 5) & 1);
            rd(3'h3, r);
            chk("pd read", r, pd_m);
            chk("dir addr", dir_addr, pd_m & 32'hFFFF_F000);
            chk("xlate", te, pd_m & 1);
            chk("late", lb2, (pd_m >> 6) & 1);
            chk("narrow", ncf, (pd_m >> 7) & 1);
            chk("repl", repl, {i == 1, i == 1 || i == 2, i == 1, i == 3, 2'(v >> 8)});
            chk("block", repl.block, (v >> 8) & 3);
        end
        for (i = 0; i < 4; i++) begin
            v = i | (i << 2);
            wr(3'h2, v);
            chk("round", rsel, i);
            @(negedge clk);
            unf = 1;
            #1 chk("uf trap", fp_trap, ~i & 1);
            chk("uf zero", fp_zero, i & 1);
            @(negedge clk);
            unf = 0;
            inx = 1;
            #1 chk("nx trap", fp_trap, (i >> 1) & 1);
            @(negedge clk);
            inx = 0;
            rd(3'h2, r);
            chk("fsr", r, v | 32'h0000_0080);
        end
        a = $urandom();
        wr(3'h4, a);
        rd(3'h4, r);
        chk("bkpt reg", r, a);
        ce = 0;
        wr(3'h4, ~a);
        ce = 1;
        rd(3'h4, r);
        chk("frozen", r, a);
        for (i = 0; i < 5; i++) begin
            access(i[0], ccr_size_t'(i), a ^ ($urandom() & ((1 << i) - 1)), 1);
            access(i[0], ccr_size_t'(i), a ^ (1 << i), 0);
        end
        rwe = 0;
        access(0, CCR_SZ_32, a, 0);
        rwe = 1;
        pulse(set_l);
        rd(3'h3, r);
        chk("lock req", r[4], 1);
        bus_u.cycle(32'h0000_1000, 1);
        chk("fetch open", lock_n, 1);
        bus_u.cycle(32'h0000_2000, 0);
        chk("locked", lock_n, 0);
        pulse(clr_l);
        chk("held", lock_n, 0);
        access(1, CCR_SZ_8, ~a, 0);
        chk("released", lock_n, 1);
        pulse(set_l);
        taddr = $urandom();
        pulse(trap);
        rd(3'h3, r);
        chk("trap clears", r[4], 0);
        rd(3'h1, r);
        chk("fir first", r, taddr);
        iaddr = $urandom();
        for (i = 0; i < 2; i++) begin
            dual = i[0];
            rd(3'h1, r);
            chk("fir later", r, iaddr - 4 * i);
        end
        for (i = 0; i < 8; i++) begin
            wr(3'h3, i << 1);
            a = $urandom();
            bus_u.cycle(a, 0);
            bus_u.cycle(a ^ (1 << (11 + i)), 0);
            chk("near", near_n, 0);
            bus_u.cycle(a ^ (1 << (12 + i)), 0);
            chk("far", near_n, 1);
        end
        rst = 1;
        strap = 1;
        repeat (2) @(negedge clk);
        rst = 0;
        wr(3'h3, 32'h0000_00C0);
        rd(3'h3, r);
        chk("strapped pd", r, 32'h0000_0080);
        chk("late strapped", lb2, 0);
        summarize();
    end
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            summarize();
        end
    end
endmodule : tb_top
bind ccr_control_regs ccr_checker chk_u (.CLK(CLK), .RST(RST), .CR_WRITE(CR_WRITE),
    .CR_SEL(CR_SEL), .CR_WDATA(CR_WDATA), .READ_WATCH_ENABLE(READ_WATCH_ENABLE),
    .WRITE_WATCH_ENABLE(WRITE_WATCH_ENABLE), .OPERAND_ACCESS(OPERAND_ACCESS),
    .ACCESS_SUPPRESS(ACCESS_SUPPRESS), .BREAKPOINT_TRAP(BREAKPOINT_TRAP),
    .BUS_CYCLE(BUS_CYCLE), .LOCK_N(LOCK_N), .NEXT_NEAR_N(NEXT_NEAR_N),
    .TRANSLATION_ENABLE(TRANSLATION_ENABLE), .DIRECTORY_ADDR(DIRECTORY_ADDR),
    .INVALIDATE_CACHES_TLB(INVALIDATE_CACHES_TLB), .LATE_BACKOFF_TWO(LATE_BACKOFF_TWO),
    .FP_UNDERFLOW(FP_UNDERFLOW), .FP_INEXACT(FP_INEXACT), .FP_RESULT_TRAP(FP_RESULT_TRAP),
    .FP_FORCE_ZERO(FP_FORCE_ZERO));
`default_nettype wire
